// >>> hdl/osp_pkg.sv
// Constants and carrier types for the oscillator supervisor and power modes.
// Assumes one 250 MHz system clock; the oscillators are seen as sampled levels.
package osp_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STAB_TIME_US = 1000;
    // Least time, rounded up to whole cycles
    localparam int STAB_CYCLES = (STAB_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SLOW_DIV = 32;
    localparam int RC_WINDOW = 16;

    // ****************************************
    // Power control register layout
    // ****************************************
    localparam int POWER_CONTROL_REGISTER_IDLE_BIT = 0;
    localparam int POWER_CONTROL_REGISTER_PD_BIT = 1;
    localparam int POWER_CONTROL_REGISTER_SLOW_BIT = 4;
    localparam int POWER_CONTROL_REGISTER_IDLE_CONF_BIT = 5;
    localparam int POWER_CONTROL_REGISTER_PD_CONF_BIT = 6;
    localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h00;

    // ****************************************
    // Program start addresses
    // ****************************************
    localparam logic [15:0] RESET_VEC = 16'h0000;
    localparam logic [15:0] WAKE_VEC = 16'h007B;

    typedef enum logic [5:0] {
        ST_FAIL = 6'h01,
        ST_STAB = 6'h02,
        ST_RUN = 6'h04,
        ST_IDLE = 6'h08,
        ST_PDOWN = 6'h10,
        ST_WAKE_STAB = 6'h20
    } osp_state_t;

    typedef struct packed {
        logic wrEn;
        logic [7:0] data;
    } osp_power_control_register_wr_t;

    typedef struct packed {
        logic mainOscEn;
        logic rcOscEn;
        logic useRcClk;
        logic cpuClkEn;
        logic periphClkEn;
    } osp_clk_ctl_t;

endpackage

// >>> hdl/osp_freq_compare.sv
// Compares main oscillator against the RC oscillator by edge counting.
// Assumes both oscillator levels are synchronous to clk and far slower than it.
`timescale 1ns/100ps
module osp_freq_compare import osp_pkg::*; #(
    parameter int WINDOW = RC_WINDOW
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic enable,
    input wire logic mainOscLevel,
    input wire logic rcOscLevel,
    output logic mainSlowQ
);

    localparam int CW = $clog2(WINDOW + 2);
    localparam logic [CW-1:0] WIN_LAST = CW'(WINDOW - 1);
    localparam logic [CW-1:0] WIN_FULL = CW'(WINDOW + 1);

    logic mainPrev_q;
    logic rcPrev_q;
    logic [CW-1:0] rcCnt_q;
    logic [CW-1:0] mainCnt_q;

    wire mainEdge = mainOscLevel && !mainPrev_q;
    wire rcEdge = rcOscLevel && !rcPrev_q;
    wire winEnd = rcEdge && (rcCnt_q == WIN_LAST);
    wire mainSat = (mainCnt_q == WIN_FULL);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mainPrev_q <= 1'b0;
            rcPrev_q <= 1'b0;
        end else if (ce) begin
            mainPrev_q <= mainOscLevel;
            rcPrev_q <= rcOscLevel;
        end
    end

    // Restart from slow so a fresh start never looks healthy early
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rcCnt_q <= '0;
            mainCnt_q <= '0;
            mainSlowQ <= 1'b1;
        end else if (ce) begin
            if (!enable) begin
                rcCnt_q <= '0;
                mainCnt_q <= '0;
                mainSlowQ <= 1'b1;
            end else if (winEnd) begin
                rcCnt_q <= '0;
                mainCnt_q <= '0;
                mainSlowQ <= !mainSat;
            end else begin
                if (rcEdge) rcCnt_q <= rcCnt_q + 1'b1;
                if (mainEdge && !mainSat) mainCnt_q <= mainCnt_q + 1'b1;
            end
        end
    end

    compare_off_a: assert property (@(posedge clk) disable iff (reset)
        ce && !enable |=> mainSlowQ) else $error("comparator not slow while off");

endmodule

// >>> hdl/osp_supervisor.sv
// Oscillator supervisor with idle, power-down and slow-down sequencing.
// Assumes a CPU core that obeys the clock enables, reset and start address.
// Function
// - Slow main oscillator: RC clock, hold reset
// - Healthy again: 1 ms stabilise, start 0000
// - Power-on reset runs from RC clock
// - Pin wake resumes at nominal clock, wake interrupt
// - Both oscillators stopped in power-down, restarted after
// - Wait 1 ms after healthy before wake interrupt
// - Idle gates CPU clock, peripherals keep clock
// - Idle ends on peripheral interrupt or reset
// - Power-down stops all, main oscillator off
// - Power-down entry: write 02H, then 40H
// - Power-down exit: reset or low wake pin
// - Slow-down divides clock by 32
// - Bit 10H enables slow-down, clear restores
// - Slow-down also applies during idle
// - Wake interrupt vectors to 007B, no flag
`timescale 1ns/100ps
module osp_supervisor import osp_pkg::*; #(
    parameter int STAB_CNT = STAB_CYCLES,
    parameter int DIV = SLOW_DIV,
    parameter int WINDOW = RC_WINDOW
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic mainOscLevel,
    input wire logic rcOscLevel,
    input wire osp_power_control_register_wr_t pconWr,
    input wire logic periphIrq,
    input wire logic wakePinA_n,
    input wire logic wakePinB_n,
    output logic [7:0] pconQ,
    output osp_clk_ctl_t clkCtlQ,
    output logic sysResetQ,
    output logic wakeIrqQ,
    output logic [15:0] startAddrQ,
    output osp_state_t stateQ
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int SW = $clog2(STAB_CNT + 1);
    localparam logic [SW-1:0] STAB_LAST = SW'(STAB_CNT - 1);
    localparam int DW = $clog2(DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

    osp_state_t state_d;
    osp_clk_ctl_t clkCtl_d;
    logic [SW-1:0] stabCnt_q;
    logic [DW-1:0] divCnt_q;
    logic idleArm_q;
    logic pdArm_q;
    logic [7:0] power_control_register_d;
    logic mainSlow;
    logic tick_d;

    function automatic logic bitOf(input logic [7:0] v, input int pos);
        bitOf = v[pos];
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    wire stFail = (stateQ == ST_FAIL);
    wire stStab = (stateQ == ST_STAB);
    wire stRun = (stateQ == ST_RUN);
    wire stIdle = (stateQ == ST_IDLE);
    wire stPd = (stateQ == ST_PDOWN);
    wire stWake = (stateQ == ST_WAKE_STAB);
    wire wr = pconWr.wrEn && stRun;
    wire wrIdle = wr && bitOf(pconWr.data, POWER_CONTROL_REGISTER_IDLE_BIT);
    wire wrIdleConf = wr && bitOf(pconWr.data, POWER_CONTROL_REGISTER_IDLE_CONF_BIT);
    wire wrPd = wr && bitOf(pconWr.data, POWER_CONTROL_REGISTER_PD_BIT);
    wire wrPdConf = wr && bitOf(pconWr.data, POWER_CONTROL_REGISTER_PD_CONF_BIT);
    wire enterPd = wrPdConf && pdArm_q;
    wire enterIdle = wrIdleConf && idleArm_q && !enterPd;
    wire wakePin = !wakePinA_n || !wakePinB_n;
    wire stabDone = (stabCnt_q == STAB_LAST);
    wire slowMode = pconQ[POWER_CONTROL_REGISTER_SLOW_BIT];
    wire leaveWake = stWake && stabDone && !mainSlow;
    wire leaveStab = stStab && stabDone && !mainSlow;

    // ****************************************
    // Frequency comparison
    // ****************************************
    // Disabled in power-down, so it restarts slow on wake
    osp_freq_compare #(
        .WINDOW(WINDOW)
    ) u_compare (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .enable(!stPd),
        .mainOscLevel(mainOscLevel),
        .rcOscLevel(rcOscLevel),
        .mainSlowQ(mainSlow)
    );

    // ****************************************
    // Mode sequencing
    // ****************************************
    always_comb begin
        state_d = stateQ;
        case (stateQ)
            ST_FAIL: begin
                if (!mainSlow) state_d = ST_STAB;
            end
            ST_STAB: begin
                if (mainSlow) state_d = ST_FAIL;
                else if (stabDone) state_d = ST_RUN;
            end
            ST_RUN: begin
                if (mainSlow) state_d = ST_FAIL;
                else if (enterPd) state_d = ST_PDOWN;
                else if (enterIdle) state_d = ST_IDLE;
            end
            ST_IDLE: begin
                if (mainSlow) state_d = ST_FAIL;
                else if (periphIrq) state_d = ST_RUN;
            end
            ST_PDOWN: begin
                if (wakePin) state_d = ST_WAKE_STAB;
            end
            ST_WAKE_STAB: begin
                // Counter holds at zero until the main oscillator wins
                if (leaveWake) state_d = ST_RUN;
            end
            default: state_d = ST_FAIL;
        endcase
    end

    // ****************************************
    // Power control register
    // ****************************************
    always_comb begin
        power_control_register_d = pconQ;
        if (wr) power_control_register_d = pconWr.data;
        if (state_d != ST_IDLE) begin
            power_control_register_d[POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
            power_control_register_d[POWER_CONTROL_REGISTER_IDLE_CONF_BIT] = 1'b0;
        end
        if (state_d != ST_PDOWN) begin
            power_control_register_d[POWER_CONTROL_REGISTER_PD_BIT] = 1'b0;
            power_control_register_d[POWER_CONTROL_REGISTER_PD_CONF_BIT] = 1'b0;
        end
    end

    // ****************************************
    // Clock controls, registered from next state
    // ****************************************
    assign tick_d = !slowMode || (divCnt_q == DIV_LAST);
    assign clkCtl_d.mainOscEn = (state_d != ST_PDOWN);
    assign clkCtl_d.rcOscEn = (state_d != ST_PDOWN);
    // RC clock stands in until the main oscillator is proven healthy
    assign clkCtl_d.useRcClk = (state_d == ST_FAIL) || ((state_d == ST_WAKE_STAB) && mainSlow);
    assign clkCtl_d.cpuClkEn = (state_d == ST_RUN) && tick_d;
    assign clkCtl_d.periphClkEn = ((state_d == ST_RUN) || (state_d == ST_IDLE)) && tick_d;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stateQ <= ST_FAIL;
            clkCtlQ <= '0;
            sysResetQ <= 1'b1;
        end else if (ce) begin
            stateQ <= state_d;
            clkCtlQ <= clkCtl_d;
            sysResetQ <= (state_d == ST_FAIL) || (state_d == ST_STAB);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pconQ <= POWER_CONTROL_REGISTER_RESET;
            idleArm_q <= 1'b0;
            pdArm_q <= 1'b0;
        end else if (ce) begin
            pconQ <= power_control_register_d;
            // Any other write breaks a two-write sequence
            if (wr) idleArm_q <= wrIdle;
            if (wr) pdArm_q <= wrPd;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stabCnt_q <= '0;
            divCnt_q <= '0;
        end else if (ce) begin
            if ((stStab || stWake) && !mainSlow && !stabDone) stabCnt_q <= stabCnt_q + 1'b1;
            else if (!(stStab || stWake) || mainSlow) stabCnt_q <= '0;
            divCnt_q <= slowMode ? divCnt_q + 1'b1 : '0;
        end
    end

    // Wake interrupt has no request flag: a single pulse only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wakeIrqQ <= 1'b0;
            startAddrQ <= RESET_VEC;
        end else if (ce) begin
            wakeIrqQ <= leaveWake;
            if (leaveWake) startAddrQ <= WAKE_VEC;
            else if (leaveStab || stFail) startAddrQ <= RESET_VEC;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    slow_forces_reset_a: assert property (ce && stRun && mainSlow |=> sysResetQ && clkCtlQ.useRcClk)
        else $error("slow oscillator did not force reset");
    release_after_stab_a: assert property ($fell(sysResetQ) |-> $past(stabDone) && startAddrQ == RESET_VEC)
        else $error("reset released without stabilisation");
    // Outputs follow next state, so check one edge on; the first edge after release still shows reset values
    fail_uses_rc_a: assert property (!reset && ce && state_d == ST_FAIL |=> stFail && clkCtlQ.useRcClk && clkCtlQ.rcOscEn && sysResetQ)
        else $error("reset phase not on RC clock");
    pd_osc_off_a: assert property (stPd |-> !clkCtlQ.mainOscEn && !clkCtlQ.rcOscEn && !clkCtlQ.periphClkEn)
        else $error("oscillators running in power-down");
    idle_gating_a: assert property (stIdle |-> clkCtlQ.mainOscEn && !clkCtlQ.cpuClkEn)
        else $error("CPU clock running in idle");
    idle_exit_a: assert property (ce && stIdle && periphIrq && !mainSlow |=> stRun)
        else $error("idle not left on interrupt");
    pd_entry_a: assert property ($rose(stPd) |-> $past(pdArm_q) && $past(pconWr.data[POWER_CONTROL_REGISTER_PD_CONF_BIT]))
        else $error("power-down entered without sequence");
    wake_exit_a: assert property (ce && stPd && !wakePinA_n |=> stWake)
        else $error("wake pin ignored");
    wake_irq_a: assert property (wakeIrqQ |-> stRun && startAddrQ == WAKE_VEC && $past(stWake))
        else $error("wake interrupt out of place");
    slow_div_a: assert property (ce && slowMode && divCnt_q != DIV_LAST |=> !clkCtlQ.cpuClkEn)
        else $error("CPU clock not divided");
    slow_clear_a: assert property (ce && wr && !pconWr.data[POWER_CONTROL_REGISTER_SLOW_BIT] |=> !slowMode)
        else $error("slow-down not cleared");
    wake_rc_a: assert property (ce && stWake && mainSlow |=> clkCtlQ.useRcClk && !sysResetQ)
        else $error("wake not on RC clock while main is slow");
    idle_slow_a: assert property (ce && stIdle && slowMode && divCnt_q != DIV_LAST && !mainSlow && !periphIrq
        |=> !clkCtlQ.periphClkEn)
        else $error("peripheral clock not divided in idle");

    wake_seen_c: cover property (wakeIrqQ);
    idle_left_c: cover property (stIdle ##1 stRun);
    slow_idle_c: cover property (stIdle && slowMode && clkCtlQ.periphClkEn);
    pd_wake_c: cover property (stPd ##1 stWake);

endmodule

// >>> test/test_osp_supervisor.sv
// Self-checking bench for the oscillator supervisor and power modes.
// Assumes osp_pkg and osp_supervisor compiled first; counts are shortened.
`timescale 1ns/100ps
module test_osp_supervisor import osp_pkg::*;;

    localparam int STAB = 20;
    localparam int WIN = 4;
    localparam int SPAN = 64;
    localparam int WATCH_NS = 25000 * 4;

    logic clk, reset, ce, periphIrq, mainOsc, rcOsc;
    logic [1:0] wakeN;
    osp_power_control_register_wr_t pconWr;
    logic [7:0] pconQ;
    osp_clk_ctl_t clkCtlQ;
    logic sysResetQ, wakeIrqQ;
    logic [15:0] startAddrQ;
    osp_state_t stateQ;
    int fails, nChecks, mainHalf, mainCnt, rcCnt;

    osp_supervisor #(.STAB_CNT(STAB), .DIV(SLOW_DIV), .WINDOW(WIN)) DUT (
        .clk(clk), .reset(reset), .ce(ce), .mainOscLevel(mainOsc), .rcOscLevel(rcOsc),
        .pconWr(pconWr), .periphIrq(periphIrq), .wakePinA_n(wakeN[0]), .wakePinB_n(wakeN[1]),
        .pconQ(pconQ), .clkCtlQ(clkCtlQ), .sysResetQ(sysResetQ), .wakeIrqQ(wakeIrqQ),
        .startAddrQ(startAddrQ), .stateQ(stateQ)
    );

    // ****************************************
    // Clock and oscillators
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    // Oscillators freeze while disabled, as real ones stop
    always @(posedge clk) begin
        if (clkCtlQ.mainOscEn) begin
            mainCnt <= (mainCnt + 1 >= mainHalf) ? 0 : mainCnt + 1;
            if (mainCnt + 1 >= mainHalf) mainOsc <= ~mainOsc;
        end
        if (clkCtlQ.rcOscEn) begin
            rcCnt <= (rcCnt + 1 >= 8) ? 0 : rcCnt + 1;
            if (rcCnt + 1 >= 8) rcOsc <= ~rcOsc;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        pconWr <= '{wrEn: 1'h1, data: d};
        @(posedge clk);
        pconWr <= '{wrEn: 1'h0, data: 8'h00};
        #1;
    endtask

    // Bounded wait; caller checks the state reached
    task automatic waitState(input osp_state_t st, output int n);
        n = 0;
        while (stateQ !== st && n < 2000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic cntEn(input logic periph, output int k);
        k = 0;
        repeat (SPAN) begin
            cyc(1);
            k += periph ? int'(clkCtlQ.periphClkEn) : int'(clkCtlQ.cpuClkEn);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(WATCH_NS);
        fails++;
        $display("BAD watchdog expected done seen hang");
        print_verdict();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        int n;
        int k;
        reset = 1'h1;
        ce = 1'h1;
        periphIrq = 1'h0;
        wakeN = 2'h3;
        pconWr = '0;
        mainOsc = 1'h0;
        rcOsc = 1'h0;
        mainHalf = 2;
        mainCnt = 0;
        rcCnt = 0;
        fails = 0;
        nChecks = 0;
        cyc(3);
        chk("stateRst", 16'(stateQ), 16'(ST_FAIL));
        chk("pconRst", 16'(pconQ), 16'(POWER_CONTROL_REGISTER_RESET));
        @(posedge clk);
        reset <= 1'h0;
        cyc(1);
        chk("rcClkPor", 16'(clkCtlQ.useRcClk), 16'h0001);
        chk("rstPor", 16'(sysResetQ), 16'h0001);
        waitState(ST_STAB, n);
        waitState(ST_RUN, n);
        chk("stabLen", 16'(n), 16'(STAB));
        chk("rstFree", 16'(sysResetQ), 16'h0000);
        chk("startAddr", startAddrQ, RESET_VEC);
        chk("mainClk", 16'(clkCtlQ.useRcClk), 16'h0000);
        $display("test power-on done");

        wr(8'h10);
        cntEn(1'h0, k);
        chk("slowCpu", 16'(k), 16'(SPAN / SLOW_DIV));
        wr(8'h00);
        cntEn(1'h0, k);
        chk("fullCpu", 16'(k), 16'(SPAN));
        $display("test slow-down done");

        wr(8'h01);
        wr(8'h00);
        wr(8'h20);
        chk("idleBroken", 16'(stateQ), 16'(ST_RUN));
        wr(8'h11);
        wr(8'h30);
        chk("idleEnter", 16'(stateQ), 16'(ST_IDLE));
        chk("idleMain", 16'(clkCtlQ.mainOscEn), 16'h0001);
        cntEn(1'h0, k);
        chk("idleCpu", 16'(k), 16'h0000);
        cntEn(1'h1, k);
        chk("idleSlowPer", 16'(k), 16'(SPAN / SLOW_DIV));
        @(posedge clk);
        periphIrq <= 1'h1;
        cyc(1);
        chk("idleExit", 16'(stateQ), 16'(ST_RUN));
        @(posedge clk);
        periphIrq <= 1'h0;
        wr(8'h00);
        $display("test idle done");

        for (int p = 0; p < 2; p++) begin
            wr(8'h02);
            wr(8'h40);
            chk("pdState", 16'(stateQ), 16'(ST_PDOWN));
            chk("pdClks", 16'(clkCtlQ), 16'h0000);
            cyc(10);
            chk("pdHold", 16'(stateQ), 16'(ST_PDOWN));
            @(posedge clk);
            wakeN[p] <= 1'h0;
            @(posedge clk);
            @(posedge clk);
            wakeN <= 2'h3;
            #1;
            chk("wakeState", 16'(stateQ), 16'(ST_WAKE_STAB));
            chk("wakeOscs", 16'({clkCtlQ.mainOscEn, clkCtlQ.rcOscEn}), 16'h0003);
            waitState(ST_RUN, n);
            chk("wakeWait", 16'(n >= STAB), 16'h0001);
            chk("wakeIrq", 16'(wakeIrqQ), 16'h0001);
            chk("wakeVec", startAddrQ, WAKE_VEC);
            chk("wakeMain", 16'(clkCtlQ.useRcClk), 16'h0000);
            cyc(1);
            chk("wakeIrqEnd", 16'(wakeIrqQ), 16'h0000);
        end
        $display("test power-down done");

        @(posedge clk);
        mainHalf <= 40;
        waitState(ST_FAIL, n);
        chk("failState", 16'(stateQ), 16'(ST_FAIL));
        chk("failRst", 16'({sysResetQ, clkCtlQ.useRcClk, clkCtlQ.cpuClkEn}), 16'h0006);
        @(posedge clk);
        mainHalf <= 2;
        waitState(ST_STAB, n);
        waitState(ST_RUN, n);
        chk("recoverLen", 16'(n), 16'(STAB));
        $display("test oscillator fail done");

        // Clock enable low: a write must not land
        wr(8'h10);
        @(posedge clk);
        ce <= 1'h0;
        wr(8'h00);
        cyc(8);
        chk("ceFreezePcon", 16'(pconQ), 16'h0010);
        chk("ceFreezeState", 16'(stateQ), 16'(ST_RUN));
        @(posedge clk);
        ce <= 1'h1;
        wr(8'h00);
        chk("ceResume", 16'(pconQ), 16'h0000);
        $display("test clock enable done");

        wr(8'h12);
        wr(8'h40);
        @(posedge clk);
        reset <= 1'h1;
        cyc(1);
        chk("pdReset", 16'(stateQ), 16'(ST_FAIL));
        chk("pdResetPcon", 16'(pconQ), 16'(POWER_CONTROL_REGISTER_RESET));
        @(posedge clk);
        reset <= 1'h0;
        waitState(ST_RUN, n);
        chk("pdResetRun", 16'(stateQ), 16'(ST_RUN));
        $display("test reset exit done");
        print_verdict();
    end

endmodule
